// [verilog/cdi_pkg.sv]
package cdi_pkg;

   // ****************************************************************
   // Register byte addresses
   // ****************************************************************
   // The port gate offset is a word index, so its byte address is four times it
   localparam logic [11:0] PORT_GATE_INDEX  = 12'h0F6;
   localparam logic [11:0] PORT_GATE_ADDR   = PORT_GATE_INDEX << 2;
   localparam logic [11:0] CTRL_ADDR        = 12'h100;
   localparam logic [11:0] PORT_READ_ADDR   = 12'h104;
   localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h108;
   localparam logic [11:0] IRQ_MASK_ADDR    = 12'h10C;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CTRL_ENABLE_BIT   = 5;
   localparam int CTRL_POS_SEL_BIT  = 4;
   localparam int CTRL_NEG_SEL_BIT  = 3;
   localparam int CTRL_PIN_OE_BIT   = 2;
   localparam int CTRL_RESULT_BIT   = 1;
   localparam int CTRL_FLAG_BIT     = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] PORT_GATE_RESET = 8'h00;

   // ****************************************************************
   // Interrupt status fields
   // ****************************************************************
   localparam int IRQ_CHANGE_BIT = 0;
   localparam int IRQ_RISE_BIT   = 1;
   localparam int IRQ_WIDTH      = 2;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS   = 4;
   localparam int SETTLE_TIME_US  = 10;
   localparam int SETTLE_CYCLES   = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [verilog/cdi_sync.sv]
`timescale 1ns/1ns
module cdi_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      sync_out
);

   logic stage_one;

   // Second stage is the only reader of the first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_one <= 1'b0;
         sync_out  <= 1'b0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule

// [verilog/cdi_input_gate.sv]
`timescale 1ns/1ns
module cdi_input_gate #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] pin_level,
   input  wire logic [WIDTH-1:0] disable_bits,
   output logic      [WIDTH-1:0] gated_level
);

   // A disabled pin reads zero regardless of its level
   for (genvar i = 0; i < WIDTH; i++) begin : g_gate
      assign gated_level[i] = pin_level[i] & ~disable_bits[i];   // [R1] [R2]
   end

endmodule

// [verilog/cdi_comparator_interface.sv]
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
// Operation
// R1: One disable bit per port 0 pin turns off that pin's digital input.
// R2: Reads of a disabled port pin return zero for that bit.
// R3: Result is one while positive input exceeds negative input, else zero.
// R4: Software selects positive input from pin A or pin B.
// R5: Software selects negative input: reference pin or internal reference.
// R6: Result readable in a register bit and optionally driven to a pin.
// R7: An interrupt can be requested whenever the result changes.
// R8: Software puts analog pins' port outputs into input-only mode.
// R9: Comparator operates only while the enable bit is set.
// R10: Flag sets on every result change; clears on write zero or disable.
// R11: Software waits 10 us after enable and clears flag before irq enable.
// R12: Raw result passes a two-stage synchronizer before use.
module cdi_comparator_interface #(
   parameter int PORT_WIDTH = 8
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [PORT_WIDTH-1:0] port_zero_pins,
   input  wire logic                  analog_pos_gt_pin_ref,
   input  wire logic                  analog_pos_gt_int_ref,
   input  wire logic                  analog_posb_gt_pin_ref,
   input  wire logic                  analog_posb_gt_int_ref,
   output logic                       positive_input_select,
   output logic                       negative_input_select,
   output logic                       analog_power_on,
   output logic                       comparator_output_pin,
   output logic                       comparator_output_pin_oe,
   output logic                       settled,
   output logic                       irq
);

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   logic        wr_en;
   logic        rd_en;
   logic        addr_hit;
   assign addr_hit = (paddr == cdi_pkg::PORT_GATE_ADDR) || (paddr == cdi_pkg::CTRL_ADDR)
                  || (paddr == cdi_pkg::PORT_READ_ADDR) || (paddr == cdi_pkg::IRQ_STATUS_ADDR)
                  || (paddr == cdi_pkg::IRQ_MASK_ADDR);
   assign wr_en   = psel && penable && pwrite && addr_hit;
   assign rd_en   = psel && !penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [PORT_WIDTH-1:0]          port_zero_input_gate;
   logic                           comparator_enable_bit;
   logic                           result_pin_output_enable;
   logic                           result_change_flag;
   logic                           synchronized_result_bit;
   logic [cdi_pkg::IRQ_WIDTH-1:0]  irq_status;
   logic [cdi_pkg::IRQ_WIDTH-1:0]  irq_mask;
   logic [PORT_WIDTH-1:0]          gated_port;
   logic                           raw_result;
   logic                           sync_result;
   logic                           prev_result;
   logic                           result_changed;
   logic [$clog2(cdi_pkg::SETTLE_CYCLES+1)-1:0] settle_count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_zero_input_gate <= cdi_pkg::PORT_GATE_RESET;
      end else if (wr_en && paddr == cdi_pkg::PORT_GATE_ADDR) begin
         port_zero_input_gate <= pwdata[PORT_WIDTH-1:0];   // [R1]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comparator_enable_bit    <= cdi_pkg::CTRL_RESET[cdi_pkg::CTRL_ENABLE_BIT];
         positive_input_select    <= cdi_pkg::CTRL_RESET[cdi_pkg::CTRL_POS_SEL_BIT];
         negative_input_select    <= cdi_pkg::CTRL_RESET[cdi_pkg::CTRL_NEG_SEL_BIT];
         result_pin_output_enable <= cdi_pkg::CTRL_RESET[cdi_pkg::CTRL_PIN_OE_BIT];
      end else if (wr_en && paddr == cdi_pkg::CTRL_ADDR) begin
         comparator_enable_bit    <= pwdata[cdi_pkg::CTRL_ENABLE_BIT];    // [R9]
         positive_input_select    <= pwdata[cdi_pkg::CTRL_POS_SEL_BIT];   // [R4]
         negative_input_select    <= pwdata[cdi_pkg::CTRL_NEG_SEL_BIT];   // [R5]
         result_pin_output_enable <= pwdata[cdi_pkg::CTRL_PIN_OE_BIT];    // [R6]
      end
   end

   assign analog_power_on = comparator_enable_bit;   // [R9]

   // ****************************************************************
   // Comparison path
   // ****************************************************************
   // The analog front end supplies each input pair's comparison; the
   // selects pick which pair counts, so switching is glitch-limited there.
   always_comb begin
      case ({positive_input_select, negative_input_select})
         2'b00:   raw_result = analog_pos_gt_pin_ref;    // [R3] [R4] [R5]
         2'b01:   raw_result = analog_pos_gt_int_ref;
         2'b10:   raw_result = analog_posb_gt_pin_ref;
         2'b11:   raw_result = analog_posb_gt_int_ref;
         default: raw_result = 1'b0;
      endcase
   end

   cdi_sync u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (raw_result & comparator_enable_bit),
      .sync_out (sync_result)
   );   // [R12]

   // Result bit reads zero while the comparator is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         synchronized_result_bit <= 1'b0;
         prev_result             <= 1'b0;
      end else if (!comparator_enable_bit) begin
         synchronized_result_bit <= 1'b0;   // [R9]
         prev_result             <= 1'b0;
      end else begin
         synchronized_result_bit <= sync_result;   // [R6] [R12]
         prev_result             <= synchronized_result_bit;
      end
   end

   assign result_changed = comparator_enable_bit && (synchronized_result_bit != prev_result);

   // Pin output carries the result whenever enabled and routed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comparator_output_pin    <= 1'b0;
         comparator_output_pin_oe <= 1'b0;
      end else begin
         comparator_output_pin    <= synchronized_result_bit;   // [R6]
         comparator_output_pin_oe <= result_pin_output_enable && comparator_enable_bit;
      end
   end

   // Settling counter: a status aid only, software still owns the wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_count <= '0;
      end else if (!comparator_enable_bit) begin
         settle_count <= '0;
      end else if (settle_count != ($bits(settle_count))'(cdi_pkg::SETTLE_CYCLES)) begin
         settle_count <= settle_count + 1'b1;   // [R11]
      end
   end
   assign settled = (settle_count == ($bits(settle_count))'(cdi_pkg::SETTLE_CYCLES));

   // ****************************************************************
   // Change flag and interrupts
   // ****************************************************************
   // Set wins over a same-cycle software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_change_flag <= 1'b0;
      end else if (!comparator_enable_bit) begin
         result_change_flag <= 1'b0;   // [R10]
      end else if (result_changed) begin
         result_change_flag <= 1'b1;   // [R7] [R10]
      end else if (wr_en && paddr == cdi_pkg::CTRL_ADDR && !pwdata[cdi_pkg::CTRL_FLAG_BIT]) begin
         result_change_flag <= 1'b0;   // [R10]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= '0;
      end else if (wr_en && paddr == cdi_pkg::IRQ_MASK_ADDR) begin
         irq_mask <= pwdata[cdi_pkg::IRQ_WIDTH-1:0];
      end
   end

   for (genvar i = 0; i < cdi_pkg::IRQ_WIDTH; i++) begin : g_irq
      logic event_hit;
      if (i == cdi_pkg::IRQ_CHANGE_BIT) begin : g_chg
         assign event_hit = result_changed;
      end else begin : g_rise
         assign event_hit = result_changed && synchronized_result_bit;
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            irq_status[i] <= 1'b0;
         end else if (event_hit) begin
            irq_status[i] <= 1'b1;   // [R7]
         end else if (wr_en && paddr == cdi_pkg::IRQ_STATUS_ADDR && pwdata[i]) begin
            irq_status[i] <= 1'b0;
         end
      end
   end

   assign irq = |(irq_status & irq_mask);   // [R7]

   // ****************************************************************
   // Read data
   // ****************************************************************
   cdi_input_gate #(
      .WIDTH (PORT_WIDTH)
   ) u_gate (
      .pin_level    (port_zero_pins),
      .disable_bits (port_zero_input_gate),
      .gated_level  (gated_port)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_en) begin
         prdata <= '0;
         case (paddr)
            cdi_pkg::PORT_GATE_ADDR: prdata[PORT_WIDTH-1:0] <= port_zero_input_gate;
            cdi_pkg::CTRL_ADDR: begin
               prdata[cdi_pkg::CTRL_ENABLE_BIT]  <= comparator_enable_bit;
               prdata[cdi_pkg::CTRL_POS_SEL_BIT] <= positive_input_select;
               prdata[cdi_pkg::CTRL_NEG_SEL_BIT] <= negative_input_select;
               prdata[cdi_pkg::CTRL_PIN_OE_BIT]  <= result_pin_output_enable;
               prdata[cdi_pkg::CTRL_RESULT_BIT]  <= synchronized_result_bit;   // [R6]
               prdata[cdi_pkg::CTRL_FLAG_BIT]    <= result_change_flag;
            end
            cdi_pkg::PORT_READ_ADDR: prdata[PORT_WIDTH-1:0] <= gated_port;   // [R2]
            cdi_pkg::IRQ_STATUS_ADDR: prdata[cdi_pkg::IRQ_WIDTH-1:0] <= irq_status;
            cdi_pkg::IRQ_MASK_ADDR: prdata[cdi_pkg::IRQ_WIDTH-1:0] <= irq_mask;
            default: prdata <= '0;
         endcase
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   gate_reads_zero_a: assert property (   // [R2]
      rd_en && paddr == cdi_pkg::PORT_READ_ADDR |=>
      ((prdata[PORT_WIDTH-1:0] & port_zero_input_gate) == '0))
      else $error("disabled port bit read non-zero");
   gate_reg_write_a: assert property (   // [R1]
      wr_en && paddr == cdi_pkg::PORT_GATE_ADDR |=>
      port_zero_input_gate == $past(pwdata[PORT_WIDTH-1:0]))
      else $error("port gate write lost");
   result_sel_a: assert property (   // [R3]
      comparator_enable_bit [*3] ##0 $stable(raw_result) [*3] |-> sync_result == raw_result)
      else $error("sync result does not follow selected comparison");
   sync_delay_a: assert property (   // [R12]
      comparator_enable_bit [*3] |-> sync_result == $past(raw_result, 2))
      else $error("synchronizer depth wrong");
   disable_clears_a: assert property (   // [R9]
      !comparator_enable_bit |=> !synchronized_result_bit && !result_change_flag)
      else $error("disabled comparator shows state");
   change_sets_flag_a: assert property (   // [R10]
      result_changed |=> result_change_flag)
      else $error("change did not set flag");
   change_irq_a: assert property (   // [R7]
      result_changed && irq_mask[cdi_pkg::IRQ_CHANGE_BIT]
      && !(wr_en && paddr == cdi_pkg::IRQ_MASK_ADDR) |=> irq)
      else $error("unmasked change did not raise irq");
   pin_output_a: assert property (   // [R6]
      comparator_enable_bit && result_pin_output_enable |=> comparator_output_pin_oe)
      else $error("result pin not enabled");
   pos_select_a: assert property (   // [R4]
      wr_en && paddr == cdi_pkg::CTRL_ADDR |=>
      positive_input_select == $past(pwdata[cdi_pkg::CTRL_POS_SEL_BIT])
      && negative_input_select == $past(pwdata[cdi_pkg::CTRL_NEG_SEL_BIT]))   // [R5]
      else $error("input select write lost");

   change_seen_c: cover property (result_changed ##[1:20] result_changed);
   irq_seen_c:    cover property (!irq ##1 irq);
   settle_c:      cover property ($rose(settled));

endmodule

// [test/cdi_analog_model.sv]
`timescale 1ns/1ns
// ****************************************************************
// Analog side: pin and reference levels seen by the comparator
// ****************************************************************
module cdi_analog_model (
   input  wire logic [3:0] level_pos_a,
   input  wire logic [3:0] level_pos_b,
   input  wire logic [3:0] level_ref_pin,
   input  wire logic [3:0] level_int_ref,
   output logic            pos_a_gt_pin_ref,
   output logic            pos_a_gt_int_ref,
   output logic            pos_b_gt_pin_ref,
   output logic            pos_b_gt_int_ref
);
   // Pins are input-only here: nothing digital ever drives them
   // Equal levels give zero, so ties exercise the strict comparison
   assign pos_a_gt_pin_ref = level_pos_a > level_ref_pin;
   assign pos_a_gt_int_ref = level_pos_a > level_int_ref;
   assign pos_b_gt_pin_ref = level_pos_b > level_ref_pin;
   assign pos_b_gt_int_ref = level_pos_b > level_int_ref;
endmodule

// [test/tb.sv]
`timescale 1ns/1ns
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, ctl;
   logic [7:0]  pins, g;
   logic [3:0]  la, lb, lr, li;
   logic        c_aa, c_ai, c_ba, c_bi, pos_sel, neg_sel, pwr, opin, opin_oe, settled;
   logic        pos, neg, oe, mid, fin, prev, ch, ri;
   logic [1:0]  exp_st, msk;
   logic [31:0] exp_q[$];
   logic        err_q[$];
   int          n_errors, num_checks, n;

   cdi_analog_model u_model (.level_pos_a(la), .level_pos_b(lb), .level_ref_pin(lr),
      .level_int_ref(li), .pos_a_gt_pin_ref(c_aa), .pos_a_gt_int_ref(c_ai),
      .pos_b_gt_pin_ref(c_ba), .pos_b_gt_int_ref(c_bi));
   cdi_comparator_interface u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_zero_pins(pins),
      .analog_pos_gt_pin_ref(c_aa), .analog_pos_gt_int_ref(c_ai),
      .analog_posb_gt_pin_ref(c_ba), .analog_posb_gt_int_ref(c_bi),
      .positive_input_select(pos_sel), .negative_input_select(neg_sel),
      .analog_power_on(pwr), .comparator_output_pin(opin),
      .comparator_output_pin_oe(opin_oe), .settled(settled), .irq(irq));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic cmpv(input logic p, input logic q);
      return (p ? lb : la) > (q ? li : lr);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ****************************************************************
   // APB master: one idle edge before each setup avoids double drives
   // ****************************************************************
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      if (k >= 50) n_errors++;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
      exp_q.push_back(e);
      err_q.push_back(er);
      xfer(1'b0, a, 32'h0);
   endtask

   // Read results are judged here as they complete, oldest note first
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         if (exp_q.size() == 0) n_errors++;
         else begin
            check(prdata, exp_q.pop_front());
            check(32'(pslverr), 32'(err_q.pop_front()));
         end
      end
   end

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      stop_test();
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; pins = 8'h00; la = 4'h0; lb = 4'h0; lr = 4'h0; li = 4'h0;
      r = 32'h3AC3; n_errors = 0; num_checks = 0; exp_st = 2'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(cdi_pkg::PORT_GATE_ADDR, 32'(cdi_pkg::PORT_GATE_RESET), 1'b0);
      rd(cdi_pkg::CTRL_ADDR, 32'(cdi_pkg::CTRL_RESET), 1'b0);
      rd(cdi_pkg::IRQ_MASK_ADDR, 32'h0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         r = xs(r);
         g = (i == 0) ? 8'hFF : r[15:8];
         pins <= r[7:0];
         wr(cdi_pkg::PORT_GATE_ADDR, {24'h0, g});
         rd(cdi_pkg::PORT_GATE_ADDR, {24'h0, g}, 1'b0);
         rd(cdi_pkg::PORT_READ_ADDR, {24'h0, r[7:0] & ~g}, 1'b0);
      end
      wr(12'h200, 32'hFFFFFFFF);
      rd(12'h200, 32'h0, 1'b1);
      // Positive above reference while still disabled: result must stay low
      la <= 4'h9; lr <= 4'h1;
      repeat (8) @(posedge pclk);
      rd(cdi_pkg::CTRL_ADDR, 32'h0, 1'b0);
      ctl = 32'h1 << cdi_pkg::CTRL_ENABLE_BIT;
      wr(cdi_pkg::CTRL_ADDR, ctl);
      n = 0;
      while (settled !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
      check(32'(settled), 32'h1);
      check(32'(pwr), 32'h1);
      wr(cdi_pkg::CTRL_ADDR, ctl);
      wr(cdi_pkg::IRQ_STATUS_ADDR, 32'h3);
      prev = 1'b1;
      for (int i = 0; i < 16; i++) begin
         r = xs(r);
         pos = r[0]; neg = r[1]; oe = r[2]; msk = r[4:3];
         ctl = (32'h1 << cdi_pkg::CTRL_ENABLE_BIT) | (32'(pos) << cdi_pkg::CTRL_POS_SEL_BIT)
             | (32'(neg) << cdi_pkg::CTRL_NEG_SEL_BIT) | (32'(oe) << cdi_pkg::CTRL_PIN_OE_BIT);
         wr(cdi_pkg::CTRL_ADDR, ctl);
         repeat (8) @(posedge pclk);
         mid = cmpv(pos, neg);
         la <= r[11:8]; lb <= r[15:12]; lr <= r[19:16]; li <= r[23:20];
         repeat (8) @(posedge pclk);
         fin = cmpv(pos, neg);
         ch = (mid != prev) || (fin != mid);
         ri = (mid && !prev) || (fin && !mid);
         exp_st = exp_st | {ri, ch};
         prev = fin;
         rd(cdi_pkg::CTRL_ADDR, ctl | (32'(fin) << cdi_pkg::CTRL_RESULT_BIT) | 32'(ch), 1'b0);
         check(32'(pos_sel), 32'(pos));
         check(32'(neg_sel), 32'(neg));
         check(32'(opin_oe), 32'(oe));
         if (oe) check(32'(opin), 32'(fin));
         wr(cdi_pkg::IRQ_MASK_ADDR, 32'(msk));
         rd(cdi_pkg::IRQ_STATUS_ADDR, 32'(exp_st), 1'b0);
         check(32'(irq), 32'(|(exp_st & msk)));
         wr(cdi_pkg::IRQ_STATUS_ADDR, 32'h3);
         exp_st = 2'h0;
      end
      // Leave the flag set with the result low, then show that a control write of zero wipes the flag and disables
      ctl = 32'h1 << cdi_pkg::CTRL_ENABLE_BIT;
      la <= 4'hF; lr <= 4'h0;
      wr(cdi_pkg::CTRL_ADDR, ctl);
      repeat (8) @(posedge pclk);
      wr(cdi_pkg::CTRL_ADDR, ctl);
      la <= 4'h0;
      repeat (8) @(posedge pclk);
      rd(cdi_pkg::CTRL_ADDR, ctl | 32'h1, 1'b0);
      wr(cdi_pkg::CTRL_ADDR, 32'h0);
      rd(cdi_pkg::CTRL_ADDR, 32'h0, 1'b0);
      check(32'(pwr), 32'h0);
      check(32'(opin_oe), 32'h0);
      repeat (4) @(posedge pclk);
      stop_test();
   end
endmodule
